// ==== core/swr_supervisor.sv ====
// swr_supervisor: power-on, low supply and watchdog reset with bus gating
module swr_supervisor #(
    parameter logic [swr_pkg::CNT_W-1:0] PWRUP_CYC = swr_pkg::ms_to_cyc(swr_pkg::PWRUP_MS),
    parameter logic [swr_pkg::CNT_W-1:0] LOWV_CYC  = swr_pkg::ms_to_cyc(swr_pkg::LOWV_MS),
    parameter logic [swr_pkg::CNT_W-1:0] WDL_CYC   = swr_pkg::ms_to_cyc(swr_pkg::WD_LONG_MS),
    parameter logic [swr_pkg::CNT_W-1:0] WDM_CYC   = swr_pkg::ms_to_cyc(swr_pkg::WD_MID_MS),
    parameter logic [swr_pkg::CNT_W-1:0] WDS_CYC   = swr_pkg::ms_to_cyc(swr_pkg::WD_SHORT_MS),
    parameter bit                        ACTIVE_HIGH = 1'b0
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              link_clk_i,
    input  wire logic              supply_ok_i,
    input  wire logic              sda_i,
    input  wire logic              scl_i,
    input  wire logic              wp_i,
    input  wire logic [7:0]        nv_ctrl_i,
    input  wire swr_pkg::swr_req_t link_req_i,
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe_o,
    output logic                   sup_rst_o,
    output logic [7:0]             nv_ctrl_o,
    output swr_pkg::swr_rsp_t      link_rsp_o
);
    import swr_pkg::*;

    // decode of the period select into a terminal count
    function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
        case (sel)
            WD_LONG:  wd_limit = WDL_CYC;
            WD_MID:   wd_limit = WDM_CYC;
            WD_SHORT: wd_limit = WDS_CYC;
            default:  wd_limit = '1;
        endcase
    endfunction

    // ---------------- core clock domain ----------------
    logic             sok_s1, sok_s2;
    logic             sda_s1, sda_s2, sda_s3;
    logic             scl_s1, scl_s2, scl_s3;
    logic             tg_s1, tg_s2, tg_s3;
    logic             sok;
    logic             start_seen;
    logic             wd_on;
    logic [CNT_W-1:0] lim;
    swr_state_t       st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] wdc_q, wdc_d;
    logic [1:0]       wd_sel_q, wd_sel_d;
    logic             rst_q, rst_d;
    logic             oe_q, oe_d;
    logic [CNT_W-1:0] ok_len_q, ok_len_d;

    // link domain signals read across
    logic             tgl_q;
    logic [7:0]       ctrl_q;

    // pin and toggle synchronisers; sda path is never gated by addressing
    always_ff @(posedge clock_i) begin
        sok_s1 <= supply_ok_i;
        sok_s2 <= sok_s1;
        sda_s1 <= sda_i;
        sda_s2 <= sda_s1;
        sda_s3 <= sda_s2;
        scl_s1 <= scl_i;
        scl_s2 <= scl_s1;
        scl_s3 <= scl_s2;
        tg_s1  <= tgl_q;
        tg_s2  <= tg_s1;
        tg_s3  <= tg_s2;
    end

    assign sok        = sok_s2;
    // start: sda falls while scl stays high, seen on second- and third-stage samples
    assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
    assign wd_on      = (wd_sel_q != WD_OFF);

    // next state: release delays, watchdog count, reset level
    always_comb begin
        st_d     = st_q;
        cnt_d    = cnt_q;
        wdc_d    = wdc_q;
        wd_sel_d = wd_sel_q;
        lim      = (st_q == ST_POR) ? PWRUP_CYC : LOWV_CYC;
        // ctrl_q is stable here: it changed before the toggle crossed over
        if (tg_s2 != tg_s3) begin
            wd_sel_d = ctrl_q[BIT_WDHI:BIT_WDLO];
        end
        case (st_q)
            ST_RUN: begin
                if (!sok) begin
                    st_d  = ST_LOWV;
                    cnt_d = '0;
                end else if (!wd_on || start_seen) begin
                    wdc_d = '0;
                end else if (wdc_q >= wd_limit(wd_sel_q) - 1'b1) begin
                    st_d  = ST_WDOG;
                    cnt_d = '0;
                end else begin
                    wdc_d = wdc_q + 1'b1;
                end
            end
            ST_POR, ST_LOWV, ST_WDOG: begin
                wdc_d = '0;
                if (!sok) begin
                    cnt_d = '0;
                    if (st_q != ST_POR) begin
                        st_d = ST_LOWV;
                    end
                end else if (cnt_q >= lim - 1'b1) begin
                    st_d  = ST_RUN;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin
                st_d  = ST_POR;
                cnt_d = '0;
                wdc_d = '0;
            end
        endcase
        rst_d = (st_d != ST_RUN);
        // open drain: active-high variant releases the pin to assert
        oe_d  = ACTIVE_HIGH ? !rst_d : rst_d;
    end

    // core registers; reset holds the output asserted
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q     <= ST_POR;
            cnt_q    <= '0;
            wdc_q    <= '0;
            wd_sel_q <= WD_OFF;
            rst_q    <= 1'b1;
            oe_q     <= !ACTIVE_HIGH;
        end else begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            wdc_q    <= wdc_d;
            wd_sel_q <= wd_sel_d;
            rst_q    <= rst_d;
            oe_q     <= oe_d;
        end
    end

    // helper for checks: run length of good supply, saturating
    always_comb begin
        ok_len_d = ok_len_q;
        if (!sok) begin
            ok_len_d = '0;
        end else if (ok_len_q != '1) begin
            ok_len_d = ok_len_q + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ok_len_q <= '0;
        end else begin
            ok_len_q <= ok_len_d;
        end
    end

    assign rst_pin_o    = 1'b0;
    assign rst_pin_oe_o = oe_q;
    assign sup_rst_o    = rst_q;

    // ---------------- link clock domain ----------------
    logic     lrst_s1, lrst_s2;
    logic     lr_s1, lr_s2, lr_s3;
    logic     wp_s1, wp_s2;
    logic     lrst_n;
    logic     ld_q, ld_d;
    logic     tgl_d;
    logic     xact_q, xact_d;
    logic     hw_prot;
    logic     go;
    logic [7:0] ctrl_d;
    swr_rsp_t rsp_q, rsp_d;

    // reset, reset level and write-protect pin into the link domain
    always_ff @(posedge link_clk_i) begin
        lrst_s1 <= rst_n_i;
        lrst_s2 <= lrst_s1;
        lr_s1   <= rst_q;
        lr_s2   <= lr_s1;
        lr_s3   <= lr_s2;
        wp_s1   <= wp_i;
        wp_s2   <= wp_s1;
    end

    assign lrst_n = lrst_s2;

    // next state: control byte, transaction tracking, write gating
    always_comb begin
        ctrl_d  = ctrl_q;
        ld_d    = 1'b1;
        tgl_d   = tgl_q;
        xact_d  = xact_q;
        rsp_d   = '0;
        go      = 1'b0;
        hw_prot = wp_s2 && ctrl_q[BIT_PROT];
        if (!ld_q) begin
            ctrl_d = nv_ctrl_i;
            tgl_d  = !tgl_q;
        end else if (link_req_i.reg_wr && !lr_s2 && !hw_prot && !rsp_q.nv_busy) begin
            ctrl_d = link_req_i.reg_wdata;
            if (wp_s2) begin
                ctrl_d[BIT_WDHI:BIT_WDLO] = ctrl_q[BIT_WDHI:BIT_WDLO];
            end
            tgl_d = !tgl_q;
            go    = 1'b1;
        end
        if (link_req_i.nv_req && !lr_s2 && !rsp_q.nv_busy) begin
            go = 1'b1;
        end
        if (lr_s2) begin
            xact_d = 1'b0;
        end else if (link_req_i.xact_start) begin
            xact_d = 1'b1;
        end else if (link_req_i.xact_end) begin
            xact_d = 1'b0;
        end
        rsp_d.xact_accept = link_req_i.xact_start && !lr_s2;
        rsp_d.xact_abort  = lr_s2 && !lr_s3 && xact_q;
        rsp_d.nv_go       = go;
        // a running write is never cut short by the reset level; only nv_done or the reset input clears nv_busy
        rsp_d.nv_busy     = go || (rsp_q.nv_busy && !link_req_i.nv_done);
    end

    // link registers
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            ctrl_q <= CTRL_RST;
            ld_q   <= 1'b0;
            tgl_q  <= 1'b0;
            xact_q <= 1'b0;
            rsp_q  <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            ld_q   <= ld_d;
            tgl_q  <= tgl_d;
            xact_q <= xact_d;
            rsp_q  <= rsp_d;
        end
    end

    assign nv_ctrl_o  = ctrl_q;
    assign link_rsp_o = rsp_q;

    // ---------------- checks, core domain ----------------
    sequence low_two_s;
        !sok [*2];
    endsequence

    sequence wd_expire_s;
        st_q == ST_RUN && sok && wd_on && !start_seen
            && wdc_q == wd_limit(wd_sel_q) - 1'b1;
    endsequence

    low_supply_rst_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !sok |=> rst_q && st_q inside {ST_POR, ST_LOWV})
        else $error("reset not asserted after low supply");

    low_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        low_two_s |-> rst_q && rst_pin_oe_o == !ACTIVE_HIGH)
        else $error("reset dropped while supply low");

    lowv_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(rst_q) && $past(st_q) == ST_LOWV |-> ok_len_q == LOWV_CYC)
        else $error("low supply release delay wrong");

    pwrup_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(rst_q) && $past(st_q) == ST_POR |-> ok_len_q == PWRUP_CYC)
        else $error("power-up release delay wrong");

    wd_timeout_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wd_expire_s |=> st_q == ST_WDOG ##0 rst_q)
        else $error("watchdog expiry did not reset");

    wd_restart_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        st_q == ST_RUN && sok && start_seen |=> wdc_q == '0 && !rst_q)
        else $error("start did not restart watchdog");

    wd_disable_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        wd_sel_q == WD_OFF && $past(wd_sel_q) == WD_OFF |-> wdc_q == '0)
        else $error("disabled watchdog counting");

    pin_polarity_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !rst_pin_o && (rst_pin_oe_o == (ACTIVE_HIGH ? !sup_rst_o : sup_rst_o)))
        else $error("reset pin polarity wrong");

    // ---------------- checks, link domain ----------------
    hw_protect_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        ld_q && wp_s2 && ctrl_q[BIT_PROT] |=> $stable(nv_ctrl_o))
        else $error("protected control byte changed");

    sel_freeze_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        ld_q && wp_s2 |=> $stable(ctrl_q[BIT_WDHI:BIT_WDLO]))
        else $error("period select changed under protect");

    xact_abort_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        lr_s2 && !lr_s3 && xact_q |=> link_rsp_o.xact_abort ##1 !link_rsp_o.xact_abort)
        else $error("transaction not aborted on reset");

    no_new_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        lr_s2 |=> !link_rsp_o.xact_accept && !link_rsp_o.nv_go)
        else $error("new activity during reset");

    nv_finish_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
        link_rsp_o.nv_busy && !link_req_i.nv_done |=> link_rsp_o.nv_busy)
        else $error("nonvolatile write cut short");

endmodule // swr_supervisor

// ==== core/swr_pkg.sv ====
// swr_pkg: constants, states and carrier types of the supervisor reset block
package swr_pkg;
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned PWRUP_MS    = 200;
    localparam int unsigned LOWV_MS     = 250;
    localparam int unsigned WD_LONG_MS  = 1400;
    localparam int unsigned WD_MID_MS   = 600;
    localparam int unsigned WD_SHORT_MS = 200;
    localparam int unsigned CNT_W       = 27;

    // control byte field positions
    localparam int unsigned BIT_PROT = 7;
    localparam int unsigned BIT_WDHI = 6;
    localparam int unsigned BIT_WDLO = 5;
    localparam logic [7:0]  CTRL_RST = 8'h00;

    // watchdog period select codes
    localparam logic [1:0] WD_LONG  = 2'h0;
    localparam logic [1:0] WD_MID   = 2'h1;
    localparam logic [1:0] WD_SHORT = 2'h2;
    localparam logic [1:0] WD_OFF   = 2'h3;

    typedef enum logic [1:0] {ST_POR, ST_RUN, ST_LOWV, ST_WDOG} swr_state_t;

    // requests from the bus protocol engine, link clock
    typedef struct packed {
        logic       xact_start;
        logic       xact_end;
        logic       nv_req;
        logic       nv_done;
        logic       reg_wr;
        logic [7:0] reg_wdata;
    } swr_req_t;

    // answers to the bus protocol engine, link clock
    typedef struct packed {
        logic xact_accept;
        logic xact_abort;
        logic nv_go;
        logic nv_busy;
    } swr_rsp_t;

    // milliseconds to core cycles, exact at this clock rate
    function automatic logic [CNT_W-1:0] ms_to_cyc(input int unsigned ms);
        ms_to_cyc = CNT_W'(64'(ms) * 64'(CLK_HZ / 1000));
    endfunction
endpackage

// ==== verif/swr_mcu_model.sv ====
// swr_mcu_model: microcontroller on the 2-wire bus issuing watchdog restarts
module swr_mcu_model #(
    parameter int unsigned GAP = 50
) (
    input  wire logic clock_i,
    input  wire logic kick_en_i,
    output logic      sda_o,
    output logic      scl_o,
    output logic      kicked_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // both lines idle high through their pull-ups; scl is never pulled here
    initial begin
        sda_o    = 1'b1;
        scl_o    = 1'b1;
        kicked_o = 1'b0;
    end

    // start condition (sda falls while scl high) well inside the short period
    always begin
        @(negedge clock_i);
        if (kick_en_i) begin
            repeat (GAP) @(negedge clock_i);
            sda_o = 1'b0;
            // low held 5 cycles so the synchroniser sees a clean level
            repeat (5) @(negedge clock_i);
            sda_o    = 1'b1;
            kicked_o = 1'b1;
            @(negedge clock_i);
            kicked_o = 1'b0;
        end
    end
endmodule // swr_mcu_model

// ==== verif/swr_supervisor_test.sv ====
// swr_supervisor_test: self-checking bench for the supervisor reset block
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module swr_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import swr_pkg::*;

    localparam logic [CNT_W-1:0] PWR  = CNT_W'(200);
    localparam logic [CNT_W-1:0] LOWV = CNT_W'(250);
    localparam logic [CNT_W-1:0] WDS  = CNT_W'(100);
    localparam logic [CNT_W-1:0] WDM  = CNT_W'(300);
    localparam logic [CNT_W-1:0] WDL  = CNT_W'(700);

    logic       clock_i  = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst_n    = 1'b0;
    logic       sup_ok   = 1'b1;
    logic       wp       = 1'b0;
    logic       kick_en  = 1'b0;
    logic       sda;
    logic       scl;
    logic       kicked;
    logic       rst_pin;
    logic       rst_oe;
    logic       sup_rst;
    logic [7:0] ctrl;
    swr_req_t   req      = '0;
    swr_rsp_t   rsp;
    swr_rsp_t   seen     = '0;
    int         bad_count = 0;
    int         n_checks  = 0;
    int         n;

    always #10 clock_i = ~clock_i;
    // link clock offset by 7 ns so its edges never meet the core clock's
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end

    swr_supervisor #(
        .PWRUP_CYC  (PWR),
        .LOWV_CYC   (LOWV),
        .WDL_CYC    (WDL),
        .WDM_CYC    (WDM),
        .WDS_CYC    (WDS),
        .ACTIVE_HIGH(1'b0)
    ) u_dut (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n),
        .link_clk_i  (link_clk),
        .supply_ok_i (sup_ok),
        .sda_i       (sda),
        .scl_i       (scl),
        .wp_i        (wp),
        .nv_ctrl_i   (8'h60),
        .link_req_i  (req),
        .rst_pin_o   (rst_pin),
        .rst_pin_oe_o(rst_oe),
        .sup_rst_o   (sup_rst),
        .nv_ctrl_o   (ctrl),
        .link_rsp_o  (rsp)
    );

    swr_mcu_model #(.GAP(50)) u_mcu (
        .clock_i  (clock_i),
        .kick_en_i(kick_en),
        .sda_o    (sda),
        .scl_o    (scl),
        .kicked_o (kicked)
    );

    // pulses are one link cycle wide, so collect them instead of timing a peek
    always @(posedge link_clk) seen <= seen | rsp;

    function automatic logic inr(input int x, input int lo, input int hi);
        return (x >= lo) && (x <= hi);
    endfunction

    task automatic wait_rst(input logic v, input int lim);
        n = 0;
        while (sup_rst !== v && n < lim) begin
            @(negedge clock_i);
            n++;
        end
    endtask

    // one link request pulse: 0 start, 1 nv request, 2 nv done, else control write
    task automatic lreq(input int k, input logic [7:0] d);
        @(negedge link_clk);
        seen = '0;
        req  = '0;
        case (k)
            0: req.xact_start = 1'b1;
            1: req.nv_req = 1'b1;
            2: req.nv_done = 1'b1;
            default: begin
                req.reg_wr    = 1'b1;
                req.reg_wdata = d;
            end
        endcase
        @(negedge link_clk);
        req = '0;
        repeat (3) @(negedge link_clk);
    endtask

    task automatic t_por;
        repeat (50) @(negedge clock_i);
        `CHK(rst_oe, 1'b1)
        `CHK(rst_pin, 1'b0)
        wait_rst(1'b0, 400);
        `CHK(inr(n + 50, PWR, PWR + 8), 1'b1)
        `CHK(rst_oe, 1'b0)
        repeat (400) @(negedge clock_i);
        `CHK(sup_rst, 1'b0)
        `CHK(ctrl, 8'h60)
    endtask

    task automatic t_ctrl;
        kick_en = 1'b1;
        lreq(3, 8'h40);
        `CHK(seen.nv_go, 1'b1)
        `CHK(ctrl, 8'h40)
        lreq(2, 8'h00);
        wp = 1'b1;
        repeat (3) @(negedge link_clk);
        lreq(3, 8'h21);
        `CHK(ctrl, 8'h41)
        lreq(2, 8'h00);
        wp = 1'b0;
        repeat (3) @(negedge link_clk);
        lreq(3, 8'hC0);
        `CHK(ctrl, 8'hC0)
        lreq(2, 8'h00);
        wp = 1'b1;
        repeat (3) @(negedge link_clk);
        lreq(3, 8'h00);
        `CHK(seen.nv_go, 1'b0)
        `CHK(ctrl, 8'hC0)
        wp = 1'b0;
    endtask

    task automatic t_wdog;
        repeat (400) @(negedge clock_i);
        `CHK(sup_rst, 1'b0)
        @(posedge kicked);
        @(negedge clock_i);
        kick_en = 1'b0;
        wait_rst(1'b1, 300);
        `CHK(inr(n, WDS - 8, WDS + 5), 1'b1)
        `CHK(rst_oe, 1'b1)
        kick_en = 1'b1;
        wait_rst(1'b0, 400);
        `CHK(inr(n, LOWV - 5, LOWV + 10), 1'b1)
    endtask

    task automatic t_low;
        // the link side sees reset fall two of its edges late; wait that out
        repeat (4) @(negedge link_clk);
        lreq(0, 8'h00);
        `CHK(seen.xact_accept, 1'b1)
        lreq(1, 8'h00);
        @(negedge clock_i);
        sup_ok = 1'b0;
        wait_rst(1'b1, 10);
        `CHK(inr(n, 2, 4), 1'b1)
        repeat (6) @(negedge link_clk);
        `CHK(seen.xact_abort, 1'b1)
        `CHK(rsp.nv_busy, 1'b1)
        lreq(0, 8'h00);
        `CHK(seen.xact_accept, 1'b0)
        lreq(2, 8'h00);
        `CHK(rsp.nv_busy, 1'b0)
        lreq(1, 8'h00);
        `CHK(seen.nv_go, 1'b0)
        @(negedge clock_i);
        sup_ok = 1'b1;
        repeat (100) @(negedge clock_i);
        sup_ok = 1'b0;
        repeat (5) @(negedge clock_i);
        `CHK(sup_rst, 1'b1)
        sup_ok = 1'b1;
        wait_rst(1'b0, 400);
        `CHK(inr(n, LOWV, LOWV + 6), 1'b1)
    endtask

    // stop restarts right after one start, return cycles until the trip
    task automatic wd_trip(output int cyc);
        @(posedge kicked);
        @(negedge clock_i);
        kick_en = 1'b0;
        wait_rst(1'b1, 1000);
        cyc = n;
        kick_en = 1'b1;
        wait_rst(1'b0, 400);
        `CHK(inr(n, LOWV - 5, LOWV + 10), 1'b1)
    endtask

    // select 01 then 00 and let each period run out with restarts stopped
    task automatic t_periods;
        int m;
        repeat (4) @(negedge link_clk);
        lreq(3, 8'hA0);
        `CHK(ctrl, 8'hA0)
        lreq(2, 8'h00);
        wd_trip(m);
        `CHK(inr(m, WDM - 8, WDM + 5), 1'b1)
        repeat (4) @(negedge link_clk);
        lreq(3, 8'h80);
        `CHK(ctrl, 8'h80)
        lreq(2, 8'h00);
        wd_trip(m);
        `CHK(inr(m, WDL - 8, WDL + 5), 1'b1)
    endtask

    task automatic print_verdict;
        $display("checks=%0d bad=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reset held 3 cycles; the link clock's phase puts one of its edges inside
    initial begin
        repeat (3) @(negedge clock_i);
        rst_n = 1'b1;
        t_por;
        t_ctrl;
        t_wdog;
        t_low;
        t_periods;
        print_verdict;
    end

    // whole sequence needs a few thousand cycles; 20000 leaves ample margin
    initial begin
        #400000;
        bad_count++;
        print_verdict;
    end
endmodule // swr_supervisor_test
